// >>> include/cib_map.svh
`ifndef CIB_MAP_SVH
`define CIB_MAP_SVH

// APB register byte offsets
`define CIB_CTRL_OFS 12'h000
`define CIB_PC_OFS 12'h004
`define CIB_STATUS_OFS 12'h008
`define CIB_LATCH_OFS 12'h00C
`define CIB_MASKPTR_OFS 12'h010
`define CIB_INDEX_BASE 12'h040
`define CIB_MODIFY_BASE 12'h080
// Control bit positions
`define CIB_CTRL_PAIRED 0
`define CIB_CTRL_BCAST1 1
`define CIB_CTRL_BCAST9 2
// Reset values
`define CIB_CTRL_RST 3'h0
`define CIB_PC_RST 24'h00_0000
`define CIB_WORD_RST 32'h0000_0000
`define CIB_STATUS_RST 2'h0
// Instruction word field positions
`define CIB_F_TYPE_MSB 47
`define CIB_F_TYPE_LSB 44
`define CIB_F_CALL 43
`define CIB_F_PCREL 42
`define CIB_F_DELAYED 41
`define CIB_F_LOOPABORT 40
`define CIB_F_CLEARINT 39
`define CIB_F_ELSE 38
`define CIB_F_COND_MSB 37
`define CIB_F_COND_LSB 33
`define CIB_F_BIDX_MSB 32
`define CIB_F_BIDX_LSB 29
`define CIB_F_BMOD_MSB 28
`define CIB_F_BMOD_LSB 25
`define CIB_F_REL_MSB 24
`define CIB_F_REL_LSB 19
`define CIB_F_DIDX_MSB 18
`define CIB_F_DIDX_LSB 15
`define CIB_F_DMOD_MSB 14
`define CIB_F_DMOD_LSB 11
`define CIB_F_DMWRITE 10
`define CIB_F_DREG_MSB 9
`define CIB_F_DREG_LSB 6
`define CIB_F_COMPUTE 5
// Opcode and condition codes
`define CIB_TYPE_BRANCH_COMP 4'h9
`define CIB_TYPE_BRANCH_DM 4'hA
`define CIB_COND_NONE 5'h1F
// Index registers whose broadcast read skips the Y offset
`define CIB_BCAST_IDX1 4'h1
`define CIB_BCAST_IDX9 4'h9

`endif

// >>> include/cib_pkg.sv
package cib_pkg;

  // Encoding width taken from the type suffix
  typedef enum logic [1:0] {
    WIDTH_FULL48 = 2'b00,
    WIDTH_MID32 = 2'b01,
    WIDTH_SHORT16 = 2'b10
  } width_t;

  typedef struct packed {
    logic take;
    logic [23:0] target;
    logic call;
    logic delayed;
    logic popLoop;
    logic popPc;
    logic clearInt;
  } branch_t;

  typedef struct packed {
    logic computeX;
    logic computeY;
    logic shadowResult;
  } peop_t;

  typedef struct packed {
    logic accessX;
    logic accessY;
    logic write;
    logic [3:0] dreg;
    logic [31:0] addrX;
    logic [31:0] addrY;
  } dmop_t;

endpackage

// >>> rtl/cond_indirect_branch_compute.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cib_map.svh"
// What this block does
// RQ1: PC-relative offset is 6-bit signed, added to PC
// RQ2: Indirect target is index plus modify, index kept
// RQ3: Delayed modifier starts a delayed branch
// RQ4: Loop abort on taken jump pops stacks
// RQ5: Repeat of in-service interrupt is not latched
// RQ6: Clear-interrupt jump clears latch and mask bits
// RQ7: Single mode takes branch if true or unconditional
// RQ8: Plain compute runs alongside the branch
// RQ9: Else compute runs when false, needs condition
// RQ10: Paired mode branches on AND of both conditions
// RQ11: Paired plain compute per element when true
// RQ12: Paired else compute per element when false
// RQ13: Y element targets complementary shadow registers
// RQ14: Short form drops the compute field
// RQ15: Data-move form jumps if true, else transfers
// RQ16: Data-move form refuses modifiers, needs condition/else
// RQ17: Data access post-modifies index with writeback
// RQ18: Data-move form only in full-width encoding
// RQ19: Paired data-move transfers in both elements
// RQ20: Type suffix selects 48, 32 or 16 bits
// RQ21: Paired Y data address is index plus one
// RQ22: Broadcast bit drops the plus one
// RQ23: Paired else-path transfer per element when false
// RQ24: One condition result drives all actions
module cond_indirect_branch_compute #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instrValid,
  input wire logic [47:0] instrWord,
  input wire cib_pkg::width_t instrWidth,
  output logic [4:0] condCode,
  input wire logic condX,
  input wire logic condY,
  input wire logic [31:0] irqReq,
  input wire logic irqEnter,
  input wire logic [4:0] irqIndex,
  input wire logic [4:0] curIrq,
  output cib_pkg::branch_t branch,
  output cib_pkg::peop_t peOp,
  output cib_pkg::dmop_t dmOp,
  output logic illegal
);

  logic [DATA_W-1:0] indexReg [16];
  logic [DATA_W-1:0] modifyReg [16];
  logic [2:0] ctrl;
  logic [23:0] pc;
  logic [31:0] irqLatch;
  logic [31:0] maskPtr;
  logic [1:0] status;

  // Register-file address decode, shared by read and write paths
  function automatic logic inBank(input logic [11:0] a,
                                  input logic [11:0] base);
    inBank = (a[11:6] == base[11:6]) && (a[1:0] == 2'b00);
  endfunction

  // Instruction fields
  logic [3:0] opType;
  logic [4:0] cond;
  logic [3:0] bIdx, bMod, dIdx, dMod;
  logic [5:0] rel;
  logic isBranchComp, isBranchDm, noCond, elseQ, compField;
  assign opType = instrWord[`CIB_F_TYPE_MSB:`CIB_F_TYPE_LSB];
  assign cond = instrWord[`CIB_F_COND_MSB:`CIB_F_COND_LSB];
  assign bIdx = instrWord[`CIB_F_BIDX_MSB:`CIB_F_BIDX_LSB];
  assign bMod = instrWord[`CIB_F_BMOD_MSB:`CIB_F_BMOD_LSB];
  assign dIdx = instrWord[`CIB_F_DIDX_MSB:`CIB_F_DIDX_LSB];
  assign dMod = instrWord[`CIB_F_DMOD_MSB:`CIB_F_DMOD_LSB];
  assign rel = instrWord[`CIB_F_REL_MSB:`CIB_F_REL_LSB];
  assign isBranchComp = opType == `CIB_TYPE_BRANCH_COMP;
  assign isBranchDm = opType == `CIB_TYPE_BRANCH_DM;
  assign noCond = cond == `CIB_COND_NONE;
  assign elseQ = instrWord[`CIB_F_ELSE];
  assign compField = instrWord[`CIB_F_COMPUTE];
  // Condition code goes to both elements in the same cycle
  assign condCode = cond;

  // Legality of form, modifiers and width
  logic badForm;
  always_comb begin
    badForm = 1'b0;
    if (isBranchComp) begin
      // Compact 16-bit form of this type carries no branch target
      if (instrWidth == cib_pkg::WIDTH_SHORT16) begin
        badForm = 1'b1; // [RQ20]
      end
      if (elseQ && noCond) begin
        badForm = 1'b1; // [RQ9]
      end
    end else if (isBranchDm) begin
      if (instrWidth != cib_pkg::WIDTH_FULL48) begin
        badForm = 1'b1; // [RQ18] [RQ20]
      end
      if (instrWord[`CIB_F_DELAYED] || instrWord[`CIB_F_LOOPABORT] ||
          instrWord[`CIB_F_CLEARINT] || noCond || !elseQ) begin
        badForm = 1'b1; // [RQ16]
      end
    end else begin
      badForm = 1'b1;
    end
  end

  // One evaluation per element, reused for every action
  logic paired, cx, cy, takeNow, validOk;
  assign paired = ctrl[`CIB_CTRL_PAIRED];
  assign validOk = instrValid && !badForm;
  assign cx = noCond || condX; // [RQ7] [RQ24]
  assign cy = noCond || condY; // [RQ24]
  assign takeNow = paired ? (cx && cy) : cx; // [RQ10] [RQ7]

  // Compute enables per element
  logic compOn, doX, doY, next_computeX, next_computeY;
  // 32-bit form has no compute field at all
  assign compOn = compField &&
                  !(isBranchComp && instrWidth == cib_pkg::WIDTH_MID32);
  always_comb begin
    doX = 1'b0;
    doY = 1'b0;
    if (isBranchDm || elseQ) begin
      doX = !cx; // [RQ9] [RQ15] [RQ23]
      doY = paired && !cy; // [RQ12] [RQ23]
    end else begin
      doX = cx; // [RQ8] [RQ11]
      doY = paired && cy; // [RQ11]
    end
  end
  assign next_computeX = validOk && compOn && doX; // [RQ14]
  assign next_computeY = validOk && compOn && doY; // [RQ19]

  // Branch target
  logic [23:0] relTarget, idxTarget, next_target;
  logic [DATA_W-1:0] idxSum;
  assign relTarget = pc + {{18{rel[5]}}, rel}; // [RQ1]
  // Sum is only driven out, never written back
  assign idxSum = indexReg[bIdx] + modifyReg[bMod]; // [RQ2]
  assign idxTarget = idxSum[23:0];
  assign next_target = instrWord[`CIB_F_PCREL] ? relTarget : idxTarget;

  // Data access addressing
  logic dmX, dmY, bcast;
  logic [DATA_W-1:0] dataAddr, postMod;
  assign dmX = validOk && isBranchDm && doX; // [RQ15]
  assign dmY = validOk && isBranchDm && doY; // [RQ19] [RQ23]
  assign dataAddr = indexReg[dIdx];
  assign postMod = dataAddr + modifyReg[dMod]; // [RQ17]
  assign bcast = (dIdx == `CIB_BCAST_IDX1 && ctrl[`CIB_CTRL_BCAST1]) ||
                 (dIdx == `CIB_BCAST_IDX9 && ctrl[`CIB_CTRL_BCAST9]);

  // Clear-interrupt event of a taken jump
  logic ciNow, isJump;
  logic [31:0] ciMask;
  assign isJump = !instrWord[`CIB_F_CALL];
  assign ciNow = validOk && takeNow && isJump &&
                 instrWord[`CIB_F_CLEARINT]; // [RQ6]
  assign ciMask = ciNow ? (32'h0000_0001 << curIrq) : 32'h0000_0000;

  // Branch outputs, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      branch <= '0;
    end else begin
      branch.take <= validOk && takeNow;
      branch.target <= next_target;
      branch.call <= validOk && takeNow && !isJump;
      branch.delayed <= validOk && takeNow &&
                        instrWord[`CIB_F_DELAYED]; // [RQ3]
      branch.popLoop <= validOk && takeNow && isJump &&
                        instrWord[`CIB_F_LOOPABORT]; // [RQ4]
      branch.popPc <= validOk && takeNow && isJump &&
                      instrWord[`CIB_F_LOOPABORT]; // [RQ4]
      branch.clearInt <= ciNow; // [RQ6]
    end
  end

  // Element compute outputs; Y writes the shadow copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peOp <= '0;
    end else begin
      peOp.computeX <= next_computeX;
      peOp.computeY <= next_computeY;
      peOp.shadowResult <= next_computeY; // [RQ13]
    end
  end

  // Data transfer outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dmOp <= '0;
    end else begin
      dmOp.accessX <= dmX;
      dmOp.accessY <= dmY;
      dmOp.write <= instrWord[`CIB_F_DMWRITE];
      dmOp.dreg <= instrWord[`CIB_F_DREG_MSB:`CIB_F_DREG_LSB];
      dmOp.addrX <= dataAddr; // [RQ17]
      dmOp.addrY <= bcast ? dataAddr : dataAddr + 1'b1; // [RQ21] [RQ22]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      illegal <= 1'b0;
    end else begin
      illegal <= instrValid && badForm; // [RQ16] [RQ18]
    end
  end

  // Program counter follows taken branches, else steps by one
  logic apbWr;
  assign apbWr = psel && penable && pwrite;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc <= `CIB_PC_RST;
    end else if (validOk) begin
      pc <= takeNow ? next_target : pc + 24'h00_0001;
    end else if (apbWr && paddr == `CIB_PC_OFS) begin
      pc <= pwdata[23:0];
    end
  end

  // Index and modify files; post-modify beats a software write
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dag
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          indexReg[gi] <= `CIB_WORD_RST;
        end else if ((dmX || dmY) && dIdx == gi) begin
          indexReg[gi] <= postMod; // [RQ17]
        end else if (apbWr && inBank(paddr, `CIB_INDEX_BASE) &&
                     paddr[5:2] == gi) begin
          indexReg[gi] <= pwdata;
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          modifyReg[gi] <= `CIB_WORD_RST;
        end else if (apbWr && inBank(paddr, `CIB_MODIFY_BASE) &&
                     paddr[5:2] == gi) begin
          modifyReg[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // Interrupt latch and mask pointer; sets win over clears
  logic [31:0] swLatchClr, swMaskClr, enterSet, next_mask;
  assign swLatchClr = (apbWr && paddr == `CIB_LATCH_OFS) ?
                      pwdata : 32'h0000_0000;
  assign swMaskClr = (apbWr && paddr == `CIB_MASKPTR_OFS) ?
                     pwdata : 32'h0000_0000;
  assign enterSet = irqEnter ? (32'h0000_0001 << irqIndex) :
                    32'h0000_0000;
  assign next_mask = (maskPtr & ~ciMask & ~swMaskClr) | enterSet; // [RQ6]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      maskPtr <= `CIB_WORD_RST;
    end else begin
      maskPtr <= next_mask;
    end
  end
  // A repeat while in service is dropped, not held for later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqLatch <= `CIB_WORD_RST;
    end else begin
      irqLatch <= (irqLatch & ~ciMask & ~swLatchClr) |
                  (irqReq & ~(maskPtr & ~ciMask)); // [RQ5] [RQ6]
    end
  end

  // Control and status registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= `CIB_CTRL_RST;
    end else if (apbWr && paddr == `CIB_CTRL_OFS) begin
      ctrl <= pwdata[2:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= `CIB_STATUS_RST;
    end else if (instrValid) begin
      status <= {badForm, validOk && takeNow};
    end
  end

  // APB slave: zero wait states, error on unmapped words
  logic mapped;
  logic [31:0] rdMux;
  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    if (paddr == `CIB_CTRL_OFS) begin
      rdMux = {29'h0000_0000, ctrl};
    end else if (paddr == `CIB_PC_OFS) begin
      rdMux = {8'h00, pc};
    end else if (paddr == `CIB_STATUS_OFS) begin
      rdMux = {30'h0000_0000, status};
    end else if (paddr == `CIB_LATCH_OFS) begin
      rdMux = irqLatch;
    end else if (paddr == `CIB_MASKPTR_OFS) begin
      rdMux = maskPtr;
    end else if (inBank(paddr, `CIB_INDEX_BASE)) begin
      rdMux = indexReg[paddr[5:2]];
    end else if (inBank(paddr, `CIB_MODIFY_BASE)) begin
      rdMux = modifyReg[paddr[5:2]];
    end else begin
      mapped = 1'b0;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // Read word caught at the setup edge so it stands through access;
  // a register changed on that same edge reads back its older value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= `CIB_WORD_RST;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end else begin
      prdata <= `CIB_WORD_RST;
    end
  end

  // Checks
  a_paired_and: assert property (@(posedge clk) disable iff (!rst_n)
    validOk && paired && !noCond && !(condX && condY) |=> !branch.take)
    else $error("paired branch taken without both conditions"); // [RQ10]
  a_single_take: assert property (@(posedge clk) disable iff (!rst_n)
    validOk && !paired && cx |=> branch.take)
    else $error("single mode branch not taken"); // [RQ7]
  a_else_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    validOk && elseQ && !paired |=> !(branch.take && peOp.computeX))
    else $error("else compute ran with branch"); // [RQ9]
  a_dm_modifiers: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && isBranchDm && instrWord[`CIB_F_DELAYED]
      |=> illegal && !branch.delayed && !dmOp.accessX)
    else $error("data-move form accepted delayed modifier"); // [RQ16]
  a_dm_width: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && isBranchDm && instrWidth != cib_pkg::WIDTH_FULL48
      |=> illegal)
    else $error("data-move form accepted in short width"); // [RQ18]
  sequence s_dmTransfer;
    dmX || dmY;
  endsequence
  a_post_modify: assert property (@(posedge clk) disable iff (!rst_n)
    s_dmTransfer |=> indexReg[$past(dIdx)] == $past(postMod))
    else $error("index not post-modified"); // [RQ17]
  a_bidx_kept: assert property (@(posedge clk) disable iff (!rst_n)
    validOk && isBranchComp && !apbWr
      |=> indexReg[$past(bIdx)] == $past(indexReg[bIdx]))
    else $error("branch index changed"); // [RQ2]
  a_y_address: assert property (@(posedge clk) disable iff (!rst_n)
    dmY && !bcast |=> dmOp.addrY == dmOp.addrX + 32'h0000_0001)
    else $error("Y address not index plus one"); // [RQ21]
  a_shadow_y: assert property (@(posedge clk) disable iff (!rst_n)
    peOp.shadowResult == peOp.computeY && (peOp.computeY -> ctrl[0]
      || $past(paired)))
    else $error("shadow result not tied to Y compute"); // [RQ13]
  a_ci_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ciNow && !irqEnter |=> !maskPtr[$past(curIrq)])
    else $error("clear-interrupt left mask bit set"); // [RQ6]
  a_repeat_drop: assert property (@(posedge clk) disable iff (!rst_n)
    maskPtr[curIrq] && !ciMask[curIrq] && !irqLatch[curIrq] &&
      irqReq[curIrq] |=> !irqLatch[$past(curIrq)])
    else $error("in-service repeat latched"); // [RQ5]
endmodule

// >>> verif/cib_pe_model.sv
`timescale 1ns/1ps
// Condition logic of the two elements; flags stand for their status bits
module cib_pe_model (
  input wire logic [4:0] condCode,
  input wire logic [31:0] flagsX,
  input wire logic [31:0] flagsY,
  output logic condX,
  output logic condY
);
  // One test per element per instruction; no code reads as true
  always_comb begin
    condX = (condCode == 5'h1F) | flagsX[condCode];
    condY = (condCode == 5'h1F) | flagsY[condCode];
  end
endmodule

// >>> verif/cond_indirect_branch_compute_tb_top.sv
`timescale 1ns/1ps
`include "cib_map.svh"
module cond_indirect_branch_compute_tb_top;
  localparam logic [11:0] IX = `CIB_INDEX_BASE;
  localparam logic [11:0] MX = `CIB_MODIFY_BASE;
  localparam logic [3:0] T9 = `CIB_TYPE_BRANCH_COMP;
  localparam logic [3:0] TA = `CIB_TYPE_BRANCH_DM;
  localparam logic [4:0] NC = `CIB_COND_NONE;
  localparam cib_pkg::width_t W48 = cib_pkg::WIDTH_FULL48;
  localparam cib_pkg::width_t W32 = cib_pkg::WIDTH_MID32;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic instrValid = 1'h0;
  logic irqEnter = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] irqReq = 32'h0000_0000;
  logic [31:0] flagsX = 32'h0000_0000;
  logic [31:0] flagsY = 32'h0000_0000;
  logic [47:0] instrWord = 48'h0000_0000_0000;
  cib_pkg::width_t instrWidth = cib_pkg::WIDTH_FULL48;
  logic [4:0] irqIndex = 5'h00;
  logic [4:0] curIrq = 5'h00;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic [4:0] condCode;
  logic condX;
  logic condY;
  logic pready;
  logic pslverr;
  logic rerr;
  logic illegal;
  cib_pkg::branch_t branch;
  cib_pkg::peop_t peOp;
  cib_pkg::dmop_t dmOp;
  int badCount = 0;
  int checks = 0;
  int cycles = 0;

  // Free-running core clock
  always #50 clk = ~clk;

  cond_indirect_branch_compute #(.DATA_W(32)) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instrValid(instrValid),
    .instrWord(instrWord), .instrWidth(instrWidth), .condCode(condCode),
    .condX(condX), .condY(condY), .irqReq(irqReq), .irqEnter(irqEnter),
    .irqIndex(irqIndex), .curIrq(curIrq), .branch(branch), .peOp(peOp),
    .dmOp(dmOp), .illegal(illegal)
  );

  cib_pe_model i_pe (
    .condCode(condCode), .flagsX(flagsX), .flagsY(flagsY),
    .condX(condX), .condY(condY)
  );

  task final_report;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cut a hang short well beyond the hundred and fifty or so cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      badCount++;
      final_report;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // Setup, then access held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  // Fields: type, call/pcrel/delay/abort/clear/else, cond, bregs, rel, dregs
  function automatic logic [47:0] ins(input logic [3:0] t,
      input logic [5:0] m, input logic [4:0] c, input logic [5:0] r,
      input logic [7:0] b, input logic [7:0] d, input logic p);
    return {t, m, c, b, r, d, 1'h0, 4'h6, p, 5'h00};
  endfunction

  // One instruction; its pulses, launched at the taking edge, are read
  // at the next edge, so every later drive stays on a rising edge
  task run(input logic [47:0] w, input cib_pkg::width_t wd);
    @(posedge clk);
    instrValid <= 1'h1;
    instrWord <= w;
    instrWidth <= wd;
    @(posedge clk);
    instrValid <= 1'h0;
    @(posedge clk);
  endtask

  task t_indirect;
    apb(1'h1, IX + 12'h00C, 32'h0000_0100);
    apb(1'h1, MX + 12'h014, 32'h0000_0020);
    run(ins(T9, 6'h00, NC, 6'h00, 8'h35, 8'h00, 1'h0), W48);
    chk(branch.take, 1'h1);
    chk(branch.target, 24'h00_0120);
    rd(IX + 12'h00C, 32'h0000_0100);
    rd(`CIB_STATUS_OFS, 32'h0000_0001);
    apb(1'h0, 12'h0FC, 32'h0000_0000);
    chk(rerr, 1'h1);
  endtask

  task t_pcrel;
    flagsX <= 32'h0000_0008;
    apb(1'h1, `CIB_PC_OFS, 32'h0000_0040);
    run(ins(T9, 6'h30, 5'h03, 6'h20, 8'h00, 8'h00, 1'h1), W48);
    chk(branch.target, 24'h00_0020);
    chk(branch.call, 1'h1);
    chk(peOp.computeX, 1'h1);
  endtask

  task t_mods;
    run(ins(T9, 6'h08, 5'h03, 6'h00, 8'h00, 8'h00, 1'h0), W48);
    chk(branch.delayed, 1'h1);
    run(ins(T9, 6'h04, 5'h03, 6'h00, 8'h00, 8'h00, 1'h0), W48);
    chk({branch.popLoop, branch.popPc}, 2'h3);
    flagsX <= 32'h0000_0000;
    run(ins(T9, 6'h04, 5'h03, 6'h00, 8'h00, 8'h00, 1'h0), W48);
    chk({branch.popLoop, branch.popPc}, 2'h0);
  endtask

  task t_irq;
    @(posedge clk);
    irqIndex <= 5'h05;
    irqEnter <= 1'h1;
    curIrq <= 5'h05;
    @(posedge clk);
    irqEnter <= 1'h0;
    irqReq <= 32'h0000_0020;
    @(posedge clk);
    irqReq <= 32'h0000_0000;
    rd(`CIB_LATCH_OFS, 32'h0000_0000);
    rd(`CIB_MASKPTR_OFS, 32'h0000_0020);
    run(ins(T9, 6'h02, NC, 6'h00, 8'h00, 8'h00, 1'h0), W48);
    chk(branch.clearInt, 1'h1);
    rd(`CIB_MASKPTR_OFS, 32'h0000_0000);
    irqReq <= 32'h0000_0020;
    @(posedge clk);
    irqReq <= 32'h0000_0000;
    rd(`CIB_LATCH_OFS, 32'h0000_0020);
  endtask

  task t_else;
    run(ins(T9, 6'h01, 5'h03, 6'h00, 8'h00, 8'h00, 1'h1), W48);
    chk({branch.take, peOp.computeX}, 2'h1);
    flagsX <= 32'h0000_0008;
    run(ins(T9, 6'h01, 5'h03, 6'h00, 8'h00, 8'h00, 1'h1), W48);
    chk({branch.take, peOp.computeX}, 2'h2);
    run(ins(T9, 6'h01, NC, 6'h00, 8'h00, 8'h00, 1'h1), W48);
    chk({illegal, branch.take}, 2'h2);
  endtask

  task t_paired;
    apb(1'h1, `CIB_CTRL_OFS, 32'h0000_0001);
    run(ins(T9, 6'h00, 5'h03, 6'h00, 8'h00, 8'h00, 1'h1), W48);
    chk(branch.take, 1'h0);
    chk({peOp.computeX, peOp.computeY}, 2'h2);
    run(ins(T9, 6'h01, 5'h03, 6'h00, 8'h00, 8'h00, 1'h1), W48);
    chk({peOp.computeX, peOp.computeY}, 2'h1);
    chk(peOp.shadowResult, 1'h1);
    flagsY <= 32'h0000_0008;
    run(ins(T9, 6'h00, 5'h03, 6'h00, 8'h00, 8'h00, 1'h1), W48);
    chk(branch.take, 1'h1);
    apb(1'h1, `CIB_CTRL_OFS, 32'h0000_0000);
  endtask

  task t_width;
    run(ins(T9, 6'h00, NC, 6'h00, 8'h00, 8'h00, 1'h1), W32);
    chk({branch.take, peOp.computeX}, 2'h2);
    run(ins(T9, 6'h00, NC, 6'h00, 8'h00, 8'h00, 1'h1),
        cib_pkg::WIDTH_SHORT16);
    chk({illegal, branch.take}, 2'h2);
  endtask

  task bad(input logic [47:0] w, input cib_pkg::width_t wd);
    run(w, wd);
    chk({illegal, branch.take, dmOp.accessX}, 3'h4);
  endtask

  task t_dmove;
    flagsX <= 32'h0000_0000;
    apb(1'h1, IX + 12'h008, 32'h0000_0200);
    apb(1'h1, MX + 12'h010, 32'h0000_0008);
    run(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h24, 1'h1), W48);
    chk({branch.take, dmOp.accessX, peOp.computeX}, 3'h3);
    chk(dmOp.addrX, 32'h0000_0200);
    chk({dmOp.write, dmOp.dreg}, 5'h06);
    rd(IX + 12'h008, 32'h0000_0208);
    flagsX <= 32'h0000_0008;
    run(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h24, 1'h1), W48);
    chk({branch.take, dmOp.accessX}, 2'h2);
    bad(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h24, 1'h0), W32);
    bad(ins(TA, 6'h09, 5'h03, 6'h00, 8'h00, 8'h24, 1'h0), W48);
    bad(ins(TA, 6'h05, 5'h03, 6'h00, 8'h00, 8'h24, 1'h0), W48);
    bad(ins(TA, 6'h03, 5'h03, 6'h00, 8'h00, 8'h24, 1'h0), W48);
    bad(ins(TA, 6'h00, 5'h03, 6'h00, 8'h00, 8'h24, 1'h0), W48);
    bad(ins(TA, 6'h01, NC, 6'h00, 8'h00, 8'h24, 1'h0), W48);
  endtask

  task t_pdmove;
    flagsX <= 32'h0000_0000;
    flagsY <= 32'h0000_0000;
    apb(1'h1, `CIB_CTRL_OFS, 32'h0000_0001);
    apb(1'h1, IX + 12'h004, 32'h0000_0300);
    apb(1'h1, MX + 12'h004, 32'h0000_0004);
    run(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h11, 1'h0), W48);
    chk({branch.take, dmOp.accessX, dmOp.accessY}, 3'h3);
    chk(dmOp.addrY, 32'h0000_0301);
    flagsX <= 32'h0000_0008;
    run(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h11, 1'h1), W48);
    chk({branch.take, dmOp.accessX, dmOp.accessY}, 3'h1);
    chk({peOp.computeX, peOp.computeY}, 2'h1);
    apb(1'h1, `CIB_CTRL_OFS, 32'h0000_0003);
    flagsX <= 32'h0000_0000;
    run(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h11, 1'h0), W48);
    chk(dmOp.addrY, 32'h0000_0308);
    flagsX <= 32'h0000_0008;
    flagsY <= 32'h0000_0008;
    run(ins(TA, 6'h01, 5'h03, 6'h00, 8'h00, 8'h11, 1'h0), W48);
    chk({branch.take, dmOp.accessY}, 2'h2);
  endtask

  // Reset for four edges, then each scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_indirect;
    t_pcrel;
    t_mods;
    t_irq;
    t_else;
    t_paired;
    t_width;
    t_dmove;
    t_pdmove;
    final_report;
  end
endmodule
